// ### logic/lcdpip_port.sv
/*
 Instruction and data port of a character display controller.
 Assumes the host strobe is synchronous and one cycle long per access.
*/
// Operation
// - Device comes up in 8-bit width after power-on reset.
// - In 4-bit width each transfer is upper nibble then lower nibble.
// - Function set bit 4 selects 8-bit; zero low bits: 1-line, default voltage.
// - Display control bits 2 and 1 turn on display and cursor; memory starts blank.
// - Entry mode bit 1 increments address and moves cursor right per write.
// - Entry mode bit 0 shifts whole display by one each display memory write.
// - Shift bit 3 selects display or cursor, bit 2 selects right or left.
// - Return home puts cursor and window back to address zero.
// - Data write stores byte in display memory, selected after power-on.
// - Display memory holds 80 character codes.
// - Display shifts move the window and step the address, never stored contents.
`timescale 1ns/1ps
`default_nettype none
module lcdpip_port #(
    parameter int OSC_CYC = lcdpip_pkg::OSC_START_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Host bus
    input wire lcdpip_pkg::lcdpip_bus_t i_bus,
    input wire logic i_power_down_pin,
    // Display side
    input wire logic [6:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    output lcdpip_pkg::lcdpip_cfg_t o_cfg,
    output logic o_busy,
    output logic o_osc_ready
);
    import lcdpip_pkg::*;

    lcdpip_st_t st_r;
    lcdpip_st_t st_nxt;
    logic [7:0] display_memory [MEM_DEPTH];
    logic [7:0] glyph_memory [64];
    logic [7:0] rd_r;
    logic [7:0] cmd;
    logic take;

    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up);
        if (up) begin
            return (a == ADDR_LAST) ? ADDR_ZERO : 7'(a + 7'h01);
        end
        return (a == ADDR_ZERO) ? ADDR_LAST : 7'(a - 7'h01);
    endfunction

    always_comb begin
        st_nxt = st_r;
        st_nxt.mem_we = 1'b0;
        st_nxt.glyph_we = 1'b0;
        take = 1'b0;
        cmd = i_bus.data;
        // Oscillator start after power-down
        if (i_power_down_pin) begin
            st_nxt.osc_ready = 1'b0;
            st_nxt.osc_cnt = '0;
        end else if (!st_r.osc_ready) begin
            if (32'(st_r.osc_cnt) >= OSC_CYC - 1) begin
                st_nxt.osc_ready = 1'b1;
            end else begin
                st_nxt.osc_cnt = 16'(st_r.osc_cnt + 16'h0001);
            end
        end
        case (st_r.state)
            LCDPIP_IDLE: begin
                st_nxt.clr_addr = ADDR_ZERO;
                st_nxt.state = LCDPIP_CLEAR;
            end
            LCDPIP_CLEAR: begin
                st_nxt.mem_we = 1'b1;
                st_nxt.mem_wa = st_r.clr_addr;
                st_nxt.mem_wd = BLANK_CHAR;
                st_nxt.clr_addr = 7'(st_r.clr_addr + 7'h01);
                if (st_r.clr_addr == ADDR_LAST) begin
                    st_nxt.state = LCDPIP_RUN;
                end
            end
            LCDPIP_RUN: begin
                if (i_bus.strobe) begin
                    if (st_r.cfg.width8) begin
                        take = 1'b1;
                    end else if (!st_r.nib_half) begin
                        st_nxt.nib_hi = i_bus.data[7:4];
                        st_nxt.nib_half = 1'b1;
                    end else begin
                        cmd = {st_r.nib_hi, i_bus.data[7:4]};
                        st_nxt.nib_half = 1'b0;
                        take = 1'b1;
                    end
                end
            end
            default: st_nxt.state = LCDPIP_IDLE;
        endcase
        if (take) begin
            if (i_bus.reg_sel) begin
                if (st_r.cfg.sel_glyph) begin
                    st_nxt.glyph_we = 1'b1;
                    st_nxt.glyph_wa = st_r.cfg.glyph_addr;
                    st_nxt.mem_wd = cmd;
                    st_nxt.cfg.glyph_addr = 6'(st_r.cfg.glyph_addr + 6'h01);
                end else begin
                    st_nxt.mem_we = 1'b1;
                    st_nxt.mem_wa = st_r.cfg.addr;
                    st_nxt.mem_wd = cmd;
                    st_nxt.cfg.addr = step_addr(st_r.cfg.addr, st_r.cfg.incr);
                    if (st_r.cfg.shift_en) begin
                        st_nxt.cfg.window = step_addr(st_r.cfg.window, st_r.cfg.incr);
                    end
                end
            end else if (cmd[OP_SET_DISPLAY_MEMORY]) begin
                st_nxt.cfg.sel_glyph = 1'b0;
                st_nxt.cfg.addr = (cmd[6:0] > ADDR_LAST) ? ADDR_ZERO : cmd[6:0];
            end else if (cmd[OP_SET_GLYPH_MEMORY]) begin
                st_nxt.cfg.sel_glyph = 1'b1;
                st_nxt.cfg.glyph_addr = cmd[5:0] & CG_ADDR_MASK;
            end else if (cmd[OP_FUNC]) begin
                st_nxt.cfg.width8 = cmd[FS_WIDTH8];
                st_nxt.cfg.two_line = cmd[FS_TWO_LINE];
                st_nxt.cfg.volt_opt = cmd[FS_VOLT];
                st_nxt.nib_half = 1'b0;
            end else if (cmd[OP_SHIFT]) begin
                st_nxt.cfg.addr = step_addr(st_r.cfg.addr, cmd[SH_RIGHT]);
                if (cmd[SH_DISP]) begin
                    st_nxt.cfg.window = step_addr(st_r.cfg.window, !cmd[SH_RIGHT]);
                end
            end else if (cmd[OP_DISPCTL]) begin
                st_nxt.cfg.disp_on = cmd[DC_DISP];
                st_nxt.cfg.cursor_on = cmd[DC_CURS];
            end else if (cmd[OP_ENTRY]) begin
                st_nxt.cfg.incr = cmd[EM_INC];
                st_nxt.cfg.shift_en = cmd[EM_SHIFT];
            end else if (cmd[OP_HOME]) begin
                st_nxt.cfg.addr = ADDR_ZERO;
                st_nxt.cfg.window = ADDR_ZERO;
                st_nxt.cfg.sel_glyph = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '0;
            st_r.state <= LCDPIP_IDLE;
            st_r.cfg.width8 <= 1'b1;
            st_r.cfg.incr <= 1'b1;
            st_r.osc_ready <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (st_r.mem_we) begin
            display_memory[st_r.mem_wa] <= st_r.mem_wd;
        end
        if (st_r.glyph_we) begin
            glyph_memory[st_r.glyph_wa] <= st_r.mem_wd;
        end
        rd_r <= (i_rd_addr > ADDR_LAST) ? BLANK_CHAR : display_memory[i_rd_addr];
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= '0;
            o_cfg <= '0;
            o_busy <= 1'b1;
            o_osc_ready <= 1'b0;
        end else begin
            o_rd_data <= rd_r;
            o_cfg <= st_r.cfg;
            o_busy <= (st_r.state != LCDPIP_RUN);
            o_osc_ready <= st_r.osc_ready;
        end
    end

    // width stays 8-bit until function set
    a_width_reset: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_r.state != LCDPIP_RUN) |-> st_r.cfg.width8)
        else $error("width not 8-bit before run");
    a_nibble_pair: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_r.state == LCDPIP_RUN && !st_r.cfg.width8 && st_r.nib_half && i_bus.strobe)
        |=> !st_r.nib_half)
        else $error("nibble pair not closed");
    a_single_access: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_r.state == LCDPIP_RUN && st_r.cfg.width8 && i_bus.strobe && !i_bus.reg_sel
        && i_bus.data[7:5] == 3'b001) |=> (st_r.cfg.width8 == $past(i_bus.data[FS_WIDTH8])))
        else $error("function set width not applied");
    a_home_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && !i_bus.reg_sel && cmd == 8'h02) |=> (st_r.cfg.addr == ADDR_ZERO
        && st_r.cfg.window == ADDR_ZERO))
        else $error("home did not zero address");
    a_addr_step: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && i_bus.reg_sel && !st_r.cfg.sel_glyph && st_r.cfg.incr
        && st_r.cfg.addr != ADDR_LAST) |=> (st_r.cfg.addr == $past(st_r.cfg.addr) + 7'h01))
        else $error("address not incremented");
    a_shift_nowrite: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && !i_bus.reg_sel && cmd[7:4] == 4'h1) |=> !st_r.mem_we)
        else $error("shift wrote memory");
    a_addr_range: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_r.cfg.addr <= ADDR_LAST)
        else $error("address beyond memory");
    a_data_store: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && i_bus.reg_sel && !st_r.cfg.sel_glyph) |=> (st_r.mem_we
        && st_r.mem_wd == $past(cmd)))
        else $error("data not stored");
    a_clear_blank: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_r.state == LCDPIP_CLEAR) |=> (st_r.mem_we && st_r.mem_wd == BLANK_CHAR))
        else $error("clear pass not blank");
    a_clear_step: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_r.state == LCDPIP_CLEAR && st_r.clr_addr != ADDR_LAST) |=> (st_r.state == LCDPIP_CLEAR
        && st_r.clr_addr == $past(st_r.clr_addr) + 7'h01))
        else $error("clear pass skipped a cell");
    // clear pass ends at last cell
    a_clear_end: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_r.state == LCDPIP_CLEAR && st_r.clr_addr == ADDR_LAST)
        |=> (st_r.state == LCDPIP_RUN))
        else $error("clear pass did not end");
    a_busy_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_r.state != LCDPIP_RUN) |=> o_busy)
        else $error("not busy during clear");
    // width changes only on a transfer
    a_width_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !take |=> $stable(st_r.cfg.width8))
        else $error("width changed without transfer");
    a_nibble_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_r.state == LCDPIP_RUN && !st_r.cfg.width8 && !st_r.nib_half && i_bus.strobe)
        |-> !take)
        else $error("first nibble executed");
    a_nibble_latch: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_r.state == LCDPIP_RUN && !st_r.cfg.width8 && !st_r.nib_half && i_bus.strobe)
        |=> (st_r.nib_half && st_r.nib_hi == $past(i_bus.data[7:4])))
        else $error("upper nibble not latched");
    // function set applies width and options
    a_func_apply: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && !i_bus.reg_sel && cmd[7:5] == 3'b001)
        |=> (st_r.cfg.width8 == $past(cmd[FS_WIDTH8])
        && st_r.cfg.two_line == $past(cmd[FS_TWO_LINE])
        && st_r.cfg.volt_opt == $past(cmd[FS_VOLT])))
        else $error("function set not applied");
    a_disp_apply: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && !i_bus.reg_sel && cmd[7:3] == 5'b00001) |=> (st_r.cfg.disp_on
        == $past(cmd[DC_DISP]) && st_r.cfg.cursor_on == $past(cmd[DC_CURS])))
        else $error("display control not applied");
    // entry mode sets step and shift
    a_entry_apply: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && !i_bus.reg_sel && cmd[7:2] == 6'b000001) |=> (st_r.cfg.incr
        == $past(cmd[EM_INC]) && st_r.cfg.shift_en == $past(cmd[EM_SHIFT])))
        else $error("entry mode not applied");
    a_window_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && i_bus.reg_sel && !st_r.cfg.shift_en) |=> $stable(st_r.cfg.window))
        else $error("window moved without shift");
    a_entry_shift: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && i_bus.reg_sel && !st_r.cfg.sel_glyph && st_r.cfg.shift_en && st_r.cfg.incr
        && st_r.cfg.window != ADDR_LAST) |=> (st_r.cfg.window == $past(st_r.cfg.window) + 7'h01))
        else $error("window not shifted on write");
    a_cursor_only: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && !i_bus.reg_sel && cmd[7:3] == 5'b00010) |=> $stable(st_r.cfg.window))
        else $error("cursor shift moved window");
    a_cursor_right: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && !i_bus.reg_sel && cmd[7:4] == 4'h1 && cmd[SH_RIGHT]
        && st_r.cfg.addr != ADDR_LAST) |=> (st_r.cfg.addr == $past(st_r.cfg.addr) + 7'h01))
        else $error("right shift did not step address");
    a_glyph_keep: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && i_bus.reg_sel && st_r.cfg.sel_glyph) |=> (!st_r.mem_we && $stable(st_r.cfg.addr)))
        else $error("glyph write touched display memory");
    a_set_addr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && !i_bus.reg_sel && cmd[OP_SET_DISPLAY_MEMORY]) |=> !st_r.cfg.sel_glyph)
        else $error("display memory not selected");
endmodule
`default_nettype wire

// ### logic/lcdpip_pkg.sv
/*
 Package of the parallel instruction port: field positions, opcodes,
 reset values, timing figures and the state record.
 Assumes a single 200 MHz clock domain.
*/
package lcdpip_pkg;
    localparam int MEM_DEPTH = 80;
    localparam int ADDR_W = 7;
    localparam logic [6:0] ADDR_LAST = 7'h4F;
    localparam logic [6:0] ADDR_ZERO = 7'h00;
    localparam logic [7:0] BLANK_CHAR = 8'h20;
    // Instruction opcode positions
    localparam int OP_SET_DISPLAY_MEMORY = 7;
    localparam int OP_SET_GLYPH_MEMORY = 6;
    localparam int OP_FUNC = 5;
    localparam int OP_SHIFT = 4;
    localparam int OP_DISPCTL = 3;
    localparam int OP_ENTRY = 2;
    localparam int OP_HOME = 1;
    // Field positions
    localparam int FS_WIDTH8 = 4;
    localparam int FS_TWO_LINE = 2;
    localparam int FS_VOLT = 0;
    localparam int DC_DISP = 2;
    localparam int DC_CURS = 1;
    localparam int EM_INC = 1;
    localparam int EM_SHIFT = 0;
    localparam int SH_DISP = 3;
    localparam int SH_RIGHT = 2;
    localparam logic [5:0] CG_ADDR_MASK = 6'h3F;
    // Oscillator start-up after power-down
    localparam int T_OSC_START_US = 300;
    localparam int CLK_MHZ = 200;
    localparam int OSC_START_CYC = T_OSC_START_US * CLK_MHZ;

    typedef enum logic [1:0] {
        LCDPIP_IDLE = 2'b00,
        LCDPIP_CLEAR = 2'b01,
        LCDPIP_RUN = 2'b10
    } lcdpip_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic reg_sel;
        logic strobe;
    } lcdpip_bus_t;

    typedef struct packed {
        logic width8;
        logic two_line;
        logic volt_opt;
        logic disp_on;
        logic cursor_on;
        logic incr;
        logic shift_en;
        logic sel_glyph;
        logic [6:0] addr;
        logic [6:0] window;
        logic [5:0] glyph_addr;
    } lcdpip_cfg_t;

    typedef struct packed {
        lcdpip_state_t state;
        logic nib_half;
        logic [3:0] nib_hi;
        logic [6:0] clr_addr;
        logic mem_we;
        logic [6:0] mem_wa;
        logic [7:0] mem_wd;
        logic glyph_we;
        logic [5:0] glyph_wa;
        logic osc_ready;
        logic [15:0] osc_cnt;
        lcdpip_cfg_t cfg;
    } lcdpip_st_t;
endpackage

// ### sim/lcdpip_host.sv
/*
 Host model for the parallel instruction port: one-cycle strobed writes.
 Assumes the port samples the bus on the rising edge of the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdpip_host (
    // Clock
    input wire logic i_clk,
    // Host bus
    output var lcdpip_pkg::lcdpip_bus_t o_bus
);
    import lcdpip_pkg::*;
    initial o_bus = '{data: 8'hFF, reg_sel: 1'b0, strobe: 1'b0};
    // One access, lines inverted once released
    task access(input logic [7:0] d, input logic rs);
        @(posedge i_clk);
        o_bus <= '{data: d, reg_sel: rs, strobe: 1'b1};
        @(posedge i_clk);
        o_bus <= '{data: ~d, reg_sel: rs, strobe: 1'b0};
    endtask
    // upper nibble first, unused lines toggling
    task put(input logic [7:0] d, input logic rs, input logic four);
        if (four) begin
            access({d[7:4], ~d[7:4]}, rs);
            access({d[3:0], ~d[3:0]}, rs);
        end else begin
            access(d, rs);
        end
    endtask
endmodule
`default_nettype wire

// ### sim/lcdpip_port_bench.sv
/*
 Self-checking bench of the parallel instruction port.
 Assumes the host model in lcdpip_host and a 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdpip_port_bench;
    import lcdpip_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_power_down_pin = 1'b0;
    logic [6:0] i_rd_addr = 7'h00;
    logic [7:0] o_rd_data;
    lcdpip_cfg_t o_cfg;
    logic o_busy;
    logic o_osc_ready;
    lcdpip_bus_t bus;
    int errors = 0;
    int n_checks = 0;
    logic four = 1'b0;
    initial forever #2.5 i_clk = ~i_clk;
    lcdpip_port #(.OSC_CYC(20)) lcdpip_port_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus(bus),
        .i_power_down_pin(i_power_down_pin), .i_rd_addr(i_rd_addr),
        .o_rd_data(o_rd_data), .o_cfg(o_cfg), .o_busy(o_busy), .o_osc_ready(o_osc_ready)
    );
    lcdpip_host lcdpip_host_i (.i_clk(i_clk), .o_bus(bus));
    task final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task ins(input logic [7:0] d, input logic rs);
        lcdpip_host_i.put(d, rs, four);
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
    endtask
    task mem(input logic [6:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd_addr <= a;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk("rd_data", exp, o_rd_data);
    endtask
    task wait_idle;
        int k;
        for (k = 0; k < 500 && o_busy !== 1'b0; k++) @(posedge i_clk);
        if (o_busy !== 1'b0) begin
            errors++;
            $display("ERROR busy expected 0 seen %b", o_busy);
            final_report();
        end
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        wait_idle();
        @(negedge i_clk);
        chk("width8", 8'h01, 8'(o_cfg.width8));
        chk("sel_glyph", 8'h00, 8'(o_cfg.sel_glyph));
        chk("addr", 8'h00, 8'(o_cfg.addr));
        mem(7'h00, BLANK_CHAR);
        mem(7'h4F, BLANK_CHAR);
        mem(7'h50, BLANK_CHAR);
        ins(8'h34, 1'b0);
        chk("two_line", 8'h01, 8'(o_cfg.two_line));
        ins(8'h30, 1'b0);
        chk("width8", 8'h01, 8'(o_cfg.width8));
        chk("two_line", 8'h00, 8'(o_cfg.two_line));
        chk("volt_opt", 8'h00, 8'(o_cfg.volt_opt));
        ins(8'h0E, 1'b0);
        chk("disp", 8'h03, 8'({o_cfg.disp_on, o_cfg.cursor_on}));
        ins(8'h06, 1'b0);
        chk("entry", 8'h02, 8'({o_cfg.incr, o_cfg.shift_en}));
        ins(8'h50, 1'b1);
        ins(8'h48, 1'b1);
        chk("addr", 8'h02, 8'(o_cfg.addr));
        chk("window", 8'h00, 8'(o_cfg.window));
        mem(7'h00, 8'h50);
        mem(7'h01, 8'h48);
        ins(8'h07, 1'b0);
        ins(8'h53, 1'b1);
        chk("window", 8'h01, 8'(o_cfg.window));
        chk("addr", 8'h03, 8'(o_cfg.addr));
        ins(8'h1C, 1'b0);
        chk("window", 8'h00, 8'(o_cfg.window));
        mem(7'h02, 8'h53);
        ins(8'h18, 1'b0);
        chk("window", 8'h01, 8'(o_cfg.window));
        ins(8'h10, 1'b0);
        chk("addr", 8'h02, 8'(o_cfg.addr));
        ins(8'h14, 1'b0);
        chk("addr", 8'h03, 8'(o_cfg.addr));
        chk("window", 8'h01, 8'(o_cfg.window));
        ins(8'h02, 1'b0);
        chk("addr", 8'h00, 8'(o_cfg.addr));
        chk("window", 8'h00, 8'(o_cfg.window));
        ins(8'h06, 1'b0);
        ins(8'hCF, 1'b0);
        chk("addr", 8'h4F, 8'(o_cfg.addr));
        ins(8'h4D, 1'b1);
        chk("addr", 8'h00, 8'(o_cfg.addr));
        mem(7'h4F, 8'h4D);
        lcdpip_host_i.access(8'h2D, 1'b0);
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk("width8", 8'h00, 8'(o_cfg.width8));
        four = 1'b1;
        ins(8'h20, 1'b0);
        chk("width8", 8'h00, 8'(o_cfg.width8));
        chk("two_line", 8'h00, 8'(o_cfg.two_line));
        ins(8'h0C, 1'b0);
        chk("disp", 8'h02, 8'({o_cfg.disp_on, o_cfg.cursor_on}));
        ins(8'h85, 1'b0);
        ins(8'h41, 1'b1);
        chk("addr", 8'h06, 8'(o_cfg.addr));
        mem(7'h05, 8'h41);
        ins(8'h45, 1'b0);
        chk("sel_glyph", 8'h01, 8'(o_cfg.sel_glyph));
        chk("glyph_addr", 8'h05, 8'(o_cfg.glyph_addr));
        ins(8'h1F, 1'b1);
        chk("glyph_addr", 8'h06, 8'(o_cfg.glyph_addr));
        chk("addr", 8'h06, 8'(o_cfg.addr));
        mem(7'h06, BLANK_CHAR);
        ins(8'h86, 1'b0);
        chk("sel_glyph", 8'h00, 8'(o_cfg.sel_glyph));
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(negedge i_clk);
        chk("busy", 8'h01, 8'(o_busy));
        four = 1'b0;
        wait_idle();
        @(negedge i_clk);
        chk("width8", 8'h01, 8'(o_cfg.width8));
        chk("addr", 8'h00, 8'(o_cfg.addr));
        mem(7'h05, BLANK_CHAR);
        ins(8'h0E, 1'b0);
        chk("disp", 8'h03, 8'({o_cfg.disp_on, o_cfg.cursor_on}));
        @(posedge i_clk);
        i_power_down_pin <= 1'b1;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk("osc_ready", 8'h00, 8'(o_osc_ready));
        @(posedge i_clk);
        i_power_down_pin <= 1'b0;
        repeat (15) @(posedge i_clk);
        @(negedge i_clk);
        chk("osc_ready", 8'h00, 8'(o_osc_ready));
        repeat (10) @(posedge i_clk);
        @(negedge i_clk);
        chk("osc_ready", 8'h01, 8'(o_osc_ready));
        final_report();
    end
endmodule
`default_nettype wire
